// *** test/eew_control_sva.sv ***
`timescale 1ns/100ps
`default_nettype none
module eew_control_sva (
    input wire logic       mclk,
    input wire logic       rst,
    input wire logic [7:0] cpuAddr,
    input wire logic [7:0] cpuWrData,
    input wire logic       cpuWr,
    input wire logic       cpuRd,
    input wire logic [7:0] cpuRdData,
    input wire logic       cpuRdValid,
    input wire logic       eepromStandby,
    input wire logic       programmingInProgress
);
    import eew_pkg::*;
    localparam int PROG = EEW_PROG_CYCLES;
    logic [8:0] busyCnt_q;
    logic [8:0] busyCnt_d;
    logic       ctrlAcc;
    logic       pageAcc;
    logic       wrStandby;
    assign ctrlAcc   = cpuAddr == EEW_CTRL_ADDR;
    assign pageAcc   = cpuAddr <= EEW_PAGE_LAST;
    assign wrStandby = cpuWrData[EEW_BIT_STANDBY];
    always_comb busyCnt_d = programmingInProgress ? busyCnt_q + 9'h001 : 9'h000;
    always_ff @(posedge mclk) busyCnt_q <= rst ? 9'h000 : busyCnt_d;
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    // ====================
    // Assertions.
    reset_idle_a: assert property ($fell(rst) |-> !programmingInProgress && !eepromStandby)
        else $error("outputs not idle after reset");
    busy_cause_a: assert property ($rose(programmingInProgress) |-> $past(cpuWr))
        else $error("busy rose without a write");
    busy_length_a: assert property ($fell(programmingInProgress) |-> busyCnt_q == PROG)
        else $error("busy length wrong");
    busy_bound_a: assert property (busyCnt_q <= PROG)
        else $error("busy too long");
    busy_read_a: assert property (cpuRd && pageAcc && programmingInProgress |=> !cpuRdValid)
        else $error("array read answered while busy");
    busy_status_a: assert property ((cpuRd && ctrlAcc && programmingInProgress) ##1 programmingInProgress
        |-> cpuRdValid && cpuRdData == 8'h02)
        else $error("busy status read wrong");
    standby_set_a: assert property (cpuWr && ctrlAcc && !programmingInProgress
        |=> eepromStandby == $past(wrStandby))
        else $error("standby does not follow write");
    ctrl_locked_a: assert property (cpuWr && ctrlAcc && programmingInProgress
        |=> eepromStandby == $past(eepromStandby))
        else $error("control written while busy");
    standby_read_a: assert property (cpuRd && pageAcc && eepromStandby |=> !cpuRdValid)
        else $error("array read answered in standby");
endmodule // eew_control_sva
bind eew_control eew_control_sva eew_control_sva_inst (.mclk(mclk), .rst(rst), .cpuAddr(cpuAddr),
    .cpuWrData(cpuWrData), .cpuWr(cpuWr), .cpuRd(cpuRd), .cpuRdData(cpuRdData), .cpuRdValid(cpuRdValid),
    .eepromStandby(eepromStandby), .programmingInProgress(programmingInProgress));
`default_nettype wire

// *** test/eew_cpu_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module eew_cpu_model (
    input  wire logic       mclk,
    input  wire logic [7:0] cpuRdData,
    input  wire logic       cpuRdValid,
    output logic      [7:0] cpuAddr,
    output logic      [7:0] cpuWrData,
    output logic            cpuWr,
    output logic            cpuRd
);
    import eew_pkg::*;
    initial begin
        cpuAddr = 8'hC0;
        cpuWrData = 8'h00;
        cpuWr = 1'b0;
        cpuRd = 1'b0;
    end
    // Whole-byte writes only; released lines show the inverse value.
    task automatic wrByte(input logic [7:0] a, input logic [7:0] x);
        @(negedge mclk);
        cpuAddr = a;
        cpuWrData = x;
        cpuWr = 1'b1;
        @(negedge mclk);
        cpuWr = 1'b0;
        cpuAddr = ~a;
        cpuWrData = ~x;
    endtask
    task automatic rdByte(input logic [7:0] a, output logic [7:0] x, output logic v);
        @(negedge mclk);
        cpuAddr = a;
        cpuRd = 1'b1;
        @(negedge mclk);
        v = cpuRdValid;
        x = cpuRdData;
        cpuRd = 1'b0;
        cpuAddr = ~a;
    endtask
    // Polls the busy flag before the next access.
    task automatic waitIdle(output logic ok);
        logic [7:0] x;
        logic       v;
        ok = 1'b0;
        for (int n = 0; n < 200 && !ok; n++) begin
            rdByte(EEW_CTRL_ADDR, x, v);
            ok = (v === 1'b1) && (x[EEW_BIT_BUSY] === 1'b0);
        end
    endtask
endmodule // eew_cpu_model
`default_nettype wire

// *** test/tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none
`define CHK(w, e, g) begin checkCount++; if ((g) !== (e)) begin errTotal++; \
    $display("mismatch %s expected %h seen %h", w, e, g); end end
module tb_top;
    import eew_pkg::*;
    logic mclk, rst, cpuWr, cpuRd, cpuRdValid, eepromStandby, programmingInProgress, v, ok;
    logic [7:0] cpuAddr, cpuWrData, cpuRdData, d;
    int errTotal = 0;
    int checkCount = 0;
    eew_control eew_control_inst (.mclk(mclk), .rst(rst), .cpuAddr(cpuAddr), .cpuWrData(cpuWrData),
        .cpuWr(cpuWr), .cpuRd(cpuRd), .cpuRdData(cpuRdData), .cpuRdValid(cpuRdValid),
        .eepromStandby(eepromStandby), .programmingInProgress(programmingInProgress));
    eew_cpu_model eew_cpu_model_inst (.mclk(mclk), .cpuRdData(cpuRdData), .cpuRdValid(cpuRdValid),
        .cpuAddr(cpuAddr), .cpuWrData(cpuWrData), .cpuWr(cpuWr), .cpuRd(cpuRd));
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] x);
        eew_cpu_model_inst.wrByte(a, x);
    endtask
    task automatic rd(input logic [7:0] a);
        eew_cpu_model_inst.rdByte(a, d, v);
    endtask
    task automatic idle();
        eew_cpu_model_inst.waitIdle(ok);
        `CHK("idle", 1'b1, ok)
    endtask
    task automatic printVerdict();
        $display("checks %0d mismatches %0d", checkCount, errTotal);
        if (errTotal == 0 && checkCount > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic tByte();
        rd(EEW_CTRL_ADDR);
        `CHK("ctrl reset", 8'h00, d)
        rd(8'h05);
        `CHK("no bank", 1'b0, v)
        wr(EEW_BANK_ADDR, 8'h01);
        rd(8'h05);
        `CHK("erased", 8'hFF, d)
        wr(8'h05, 8'h5A);
        `CHK("no enable", 1'b0, programmingInProgress)
        rd(8'h05);
        `CHK("no write", 8'hFF, d)
        wr(EEW_CTRL_ADDR, 8'h01);
        wr(8'h05, 8'hA5);
        `CHK("busy on", 1'b1, programmingInProgress)
        rd(8'h05);
        `CHK("aborted", 1'b0, v)
        wr(EEW_CTRL_ADDR, 8'h40);
        `CHK("locked", 1'b0, eepromStandby)
        rd(EEW_CTRL_ADDR);
        `CHK("busy flag", 8'h02, d)
        idle();
        rd(8'h05);
        `CHK("byte", 8'hA5, d)
        wr(EEW_BANK_ADDR, 8'h02);
        rd(8'h05);
        `CHK("page one", 8'hFF, d)
        wr(EEW_BANK_ADDR, 8'h01);
        $display("test byte done");
    endtask
    task automatic tPar();
        logic [7:0] pa [5] = '{8'h18, 8'h19, 8'h1A, 8'h1B, 8'h20};
        logic [7:0] pe [5] = '{8'h11, 8'hFF, 8'h22, 8'h33, 8'hFF};
        wr(EEW_CTRL_ADDR, 8'h05);
        wr(8'h18, 8'h11);
        wr(8'h1A, 8'h22);
        wr(8'h1B, 8'h33);
        wr(8'h20, 8'h44);
        `CHK("loading", 1'b0, programmingInProgress)
        wr(EEW_CTRL_ADDR, 8'h0D);
        `CHK("row busy", 1'b1, programmingInProgress)
        idle();
        for (int i = 0; i < 5; i++) begin
            rd(pa[i]);
            `CHK("row byte", pe[i], d)
        end
        wr(EEW_CTRL_ADDR, 8'h09);
        `CHK("no start", 1'b0, programmingInProgress)
        wr(8'h1C, 8'h77);
        `CHK("byte after row", 1'b1, programmingInProgress)
        idle();
        wr(EEW_CTRL_ADDR, 8'h05);
        wr(8'h28, 8'h55);
        wr(EEW_CTRL_ADDR, 8'h01);
        `CHK("cancel", 1'b0, programmingInProgress)
        rd(8'h28);
        `CHK("discarded", 8'hFF, d)
        wr(EEW_CTRL_ADDR, 8'h05);
        wr(8'h29, 8'h66);
        wr(EEW_CTRL_ADDR, 8'h0D);
        `CHK("second row busy", 1'b1, programmingInProgress)
        idle();
        rd(8'h29);
        `CHK("second row byte", 8'h66, d)
        rd(8'h28);
        `CHK("latches cleared", 8'hFF, d)
        $display("test parallel done");
    endtask
    task automatic tStandby();
        wr(EEW_CTRL_ADDR, 8'h40);
        `CHK("standby", 1'b1, eepromStandby)
        rd(8'h05);
        `CHK("standby read", 1'b0, v)
        wr(EEW_CTRL_ADDR, 8'h00);
        rd(8'h1C);
        `CHK("wake read", 8'h77, d)
        $display("test standby done");
    endtask
    initial begin
        repeat (20000) @(posedge mclk);
        errTotal++;
        printVerdict();
    end
    initial begin
        rst = 1'b1;
        repeat (5) @(negedge mclk);
        rst = 1'b0;
        tByte();
        tPar();
        tStandby();
        printVerdict();
    end
endmodule // tb_top
`default_nettype wire

// *** verilog/eew_control.sv ***
// Function
// (RULE1) Standby bit disables array, accesses meaningless.
// (RULE2) Start bit programs whole loaded row.
// (RULE3) Start bit self-clears when programming ends.
// (RULE4) Unloaded row bytes keep old contents.
// (RULE5) Mode bit set: writes go to latches.
// (RULE6) Row fixed by A7..A3; A2..A0 select byte.
// (RULE7) Mode bit self-clears after parallel programming.
// (RULE8) Clearing mode bit discards loaded row.
// (RULE9) Busy flag high throughout programming.
// (RULE10) Accesses while busy aborted; cycle completes.
// (RULE11) Software tests busy before every access.
// (RULE12) Enable bit low: no write cycle.
// (RULE13) Software sets enable before any write.
// (RULE14) Software writes control register whole byte.
// (RULE15) Control register at DFh, resets 00h.
// (RULE16) Unprogrammed cells read erased FFh.
// (RULE17) Start sets only with enable and mode.
// (RULE18) Mode set clears latches, latches row.
// (RULE19) Control writes ignored while busy.
// (RULE20) Pages at 00h-3Fh, bank select chooses.
// (RULE21) Byte write starts one cycle, busy.
`timescale 1ns/100ps
`default_nettype none
module eew_control (
    input  wire logic       mclk,
    input  wire logic       rst,
    input  wire logic [7:0] cpuAddr,
    input  wire logic [7:0] cpuWrData,
    input  wire logic       cpuWr,
    input  wire logic       cpuRd,
    output logic      [7:0] cpuRdData,
    output logic            cpuRdValid,
    output logic            eepromStandby,
    output logic            programmingInProgress
);
    import eew_pkg::*;
    // ==========================================================
    // Control and bank state.
    logic [7:0]           ctrl_q, ctrl_d;
    logic [7:0]           bank_q, bank_d;
    logic [4:0]           row_q, row_d;
    logic                 rowSet_q, rowSet_d;
    logic                 pageSel_q, pageSel_d;
    eew_state_e           state_q, state_d;
    logic [EEW_CNT_W-1:0] cnt_q, cnt_d;
    logic [2:0]           idx_q, idx_d;
    logic [EEW_MEM_AW-1:0] byteAddr_q, byteAddr_d;
    logic [7:0]           byteData_q, byteData_d;
    logic                 rdPend_q, rdPend_d;
    logic                 rdCtrl_q, rdCtrl_d;
    logic [7:0]           ctrlRd_q, ctrlRd_d;
    logic                 standby, pmode, progEn, busy;
    logic                 pageHit, pageValid, pageBit;
    logic                 ctrlWr, arrWr, arrRd;
    logic                 latchClear;
    logic [EEW_ROW_BYTES-1:0] latchLoad, latchLoaded;
    logic [7:0]           latchData [0:EEW_ROW_BYTES-1];
    logic                 memWe;
    logic [EEW_MEM_AW-1:0] memWrAddr, memRdAddr;
    logic [7:0]           memWrData, memRdData;
    assign standby = ctrl_q[EEW_BIT_STANDBY];
    assign pmode   = ctrl_q[EEW_BIT_PMODE];
    assign progEn  = ctrl_q[EEW_BIT_PROGEN];
    assign busy    = (state_q != EEW_IDLE);
    // ==========================================================
    // Decode of the paged window.
    assign pageHit   = (cpuAddr <= EEW_PAGE_LAST); // RULE20
    assign pageValid = bank_q[EEW_BANK_PAGE0] ^ bank_q[EEW_BANK_PAGE1]; // RULE20
    assign pageBit   = bank_q[EEW_BANK_PAGE1];
    assign ctrlWr    = cpuWr && (cpuAddr == EEW_CTRL_ADDR) && !busy; // RULE19
    assign arrWr     = cpuWr && pageHit && pageValid && !standby && !busy; // RULE1 RULE10
    assign arrRd     = cpuRd && pageHit && pageValid && !standby && !busy; // RULE1 RULE10
    // ==========================================================
    // Row latches.
    assign latchClear = ctrlWr && cpuWrData[EEW_BIT_PMODE] && !pmode; // RULE18
    always_comb begin
        for (int i = 0; i < EEW_ROW_BYTES; i++) begin
            latchLoad[i] = arrWr && pmode && !ctrl_q[EEW_BIT_PSTART]
                && (cpuAddr[2:0] == 3'(i)) // RULE6
                && (!rowSet_q || (row_q == cpuAddr[7:3] && pageSel_q == pageBit)); // RULE5 RULE6
        end
    end
    genvar g;
    generate
        for (g = 0; g < EEW_ROW_BYTES; g++) begin : gRow
            eew_row_latch uLatch (
                .mclk     (mclk),
                .rst      (rst),
                .clear    (latchClear),
                .load     (latchLoad[g]),
                .loadData (cpuWrData),
                .data     (latchData[g]),
                .loaded   (latchLoaded[g])
            );
        end
    endgenerate
    // ==========================================================
    // Programming sequencer and register updates.
    always_comb begin
        ctrl_d     = ctrl_q;
        bank_d     = bank_q;
        row_d      = row_q;
        rowSet_d   = rowSet_q;
        pageSel_d  = pageSel_q;
        state_d    = state_q;
        cnt_d      = cnt_q;
        idx_d      = idx_q;
        byteAddr_d = byteAddr_q;
        byteData_d = byteData_q;
        memWe      = 1'b0;
        memWrAddr  = byteAddr_q;
        memWrData  = byteData_q;
        if (cpuWr && cpuAddr == EEW_BANK_ADDR) begin
            bank_d = cpuWrData;
        end
        if (ctrlWr) begin
            ctrl_d[7:4] = {1'b0, cpuWrData[EEW_BIT_STANDBY], 2'b00}; // RULE1
            ctrl_d[EEW_BIT_PMODE]  = cpuWrData[EEW_BIT_PMODE];
            ctrl_d[EEW_BIT_PROGEN] = cpuWrData[EEW_BIT_PROGEN];
            if (!cpuWrData[EEW_BIT_PMODE]) begin
                rowSet_d = 1'b0; // RULE8
            end
            if (cpuWrData[EEW_BIT_PMODE] && !pmode) begin
                rowSet_d = 1'b0; // RULE18
            end
            if (cpuWrData[EEW_BIT_PSTART] && progEn && pmode && cpuWrData[EEW_BIT_PMODE]
                && cpuWrData[EEW_BIT_PROGEN]) begin
                ctrl_d[EEW_BIT_PSTART] = 1'b1; // RULE17
                state_d = EEW_ROWPROG; // RULE2
                cnt_d   = '0;
                idx_d   = '0;
            end
        end
        if (arrWr && pmode && !rowSet_q) begin
            rowSet_d  = 1'b1; // RULE18
            row_d     = cpuAddr[7:3];
            pageSel_d = pageBit;
        end
        if (arrWr && !pmode && progEn && state_q == EEW_IDLE) begin
            state_d    = EEW_BYTE; // RULE21
            cnt_d      = '0;
            byteAddr_d = {pageBit, cpuAddr[5:0]};
            byteData_d = cpuWrData;
        end // RULE12
        case (state_q)
            EEW_IDLE: begin
            end
            EEW_BYTE: begin
                cnt_d = cnt_q + 1'b1;
                if (cnt_q == EEW_CNT_W'(EEW_PROG_CYCLES - 1)) begin
                    memWe   = 1'b1;
                    state_d = EEW_IDLE; // RULE9
                end
            end
            EEW_ROWPROG: begin
                memWrAddr = {pageSel_q, row_q[2:0], idx_q}; // RULE6
                memWrData = latchData[idx_q];
                memWe     = latchLoaded[idx_q] && rowSet_q; // RULE4
                idx_d     = idx_q + 1'b1;
                cnt_d     = cnt_q + 1'b1;
                if (cnt_q == EEW_CNT_W'(EEW_PROG_CYCLES - 1)) begin
                    state_d  = EEW_IDLE; // RULE9
                    ctrl_d[EEW_BIT_PSTART] = 1'b0; // RULE3
                    ctrl_d[EEW_BIT_PMODE]  = 1'b0; // RULE7
                    rowSet_d = 1'b0;
                end
            end
            default: begin
                state_d = EEW_IDLE;
            end
        endcase
    end
    always_ff @(posedge mclk) begin
        if (rst) begin
            ctrl_q     <= EEW_CTRL_RESET; // RULE15
            bank_q     <= EEW_BANK_RESET;
            row_q      <= '0;
            rowSet_q   <= 1'b0;
            pageSel_q  <= 1'b0;
            state_q    <= EEW_IDLE;
            cnt_q      <= '0;
            idx_q      <= '0;
            byteAddr_q <= '0;
            byteData_q <= 8'h00;
        end else begin
            ctrl_q     <= ctrl_d;
            bank_q     <= bank_d;
            row_q      <= row_d;
            rowSet_q   <= rowSet_d;
            pageSel_q  <= pageSel_d;
            state_q    <= state_d;
            cnt_q      <= cnt_d;
            idx_q      <= idx_d;
            byteAddr_q <= byteAddr_d;
            byteData_q <= byteData_d;
        end
    end
    // ==========================================================
    // Array and read path.
    assign memRdAddr = {pageBit, cpuAddr[5:0]};
    eew_mem uMem (
        .mclk   (mclk),
        .we     (memWe),
        .wrAddr (memWrAddr),
        .wrData (memWrData),
        .rdAddr (memRdAddr),
        .rdData (memRdData)
    );
    always_comb begin
        rdPend_d = arrRd;
        rdCtrl_d = cpuRd && (cpuAddr == EEW_CTRL_ADDR);
        ctrlRd_d = 8'h00;
        ctrlRd_d[EEW_BIT_BUSY] = busy; // RULE9 RULE19
    end
    always_ff @(posedge mclk) begin
        if (rst) begin
            rdPend_q <= 1'b0;
            rdCtrl_q <= 1'b0;
            ctrlRd_q <= 8'h00;
        end else begin
            rdPend_q <= rdPend_d;
            rdCtrl_q <= rdCtrl_d;
            ctrlRd_q <= ctrlRd_d;
        end
    end
    assign cpuRdData  = rdCtrl_q ? ctrlRd_q : (rdPend_q ? memRdData : 8'h00);
    assign cpuRdValid = rdPend_q || rdCtrl_q;
    assign eepromStandby         = standby; // RULE1
    assign programmingInProgress = busy; // RULE9
endmodule // eew_control
`default_nettype wire

// *** verilog/eew_mem.sv ***
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// Storage array with registered read data, erased to all ones.
module eew_mem (
    input  wire logic                         mclk,
    input  wire logic                         we,
    input  wire logic [eew_pkg::EEW_MEM_AW-1:0] wrAddr,
    input  wire logic [7:0]                   wrData,
    input  wire logic [eew_pkg::EEW_MEM_AW-1:0] rdAddr,
    output logic      [7:0]                   rdData
);
    import eew_pkg::*;
    logic [7:0] cells [0:EEW_MEM_WORDS-1];
    initial begin
        for (int i = 0; i < EEW_MEM_WORDS; i++) begin
            cells[i] = EEW_ERASED; // RULE16
        end
    end
    always_ff @(posedge mclk) begin
        if (we) begin
            cells[wrAddr] <= wrData;
        end
        rdData <= cells[rdAddr];
    end
endmodule // eew_mem
`default_nettype wire

// *** verilog/eew_pkg.sv ***
package eew_pkg;
    // ==========================================================
    // Data space map.
    localparam logic [7:0] EEW_CTRL_ADDR      = 8'hDF;
    localparam logic [7:0] EEW_BANK_ADDR      = 8'hCB;
    localparam logic [7:0] EEW_PAGE_LAST      = 8'h3F;
    localparam logic [7:0] EEW_CTRL_RESET     = 8'h00;
    localparam logic [7:0] EEW_BANK_RESET     = 8'h00;
    localparam logic [7:0] EEW_ERASED         = 8'hFF;
    // ==========================================================
    // Control register fields.
    localparam int EEW_BIT_STANDBY   = 6;
    localparam int EEW_BIT_PSTART    = 3;
    localparam int EEW_BIT_PMODE     = 2;
    localparam int EEW_BIT_BUSY      = 1;
    localparam int EEW_BIT_PROGEN    = 0;
    // ==========================================================
    // Bank select fields.
    localparam int EEW_BANK_PAGE0    = 0;
    localparam int EEW_BANK_PAGE1    = 1;
    // ==========================================================
    // Geometry.
    localparam int EEW_ROW_BYTES     = 8;
    localparam int EEW_MEM_WORDS     = 128;
    localparam int EEW_MEM_AW        = 7;
    // ==========================================================
    // Timing.
    localparam int EEW_CLK_HZ        = 40000000;
    localparam int EEW_PROG_TIME_US  = 5;
    localparam int EEW_PROG_CYCLES   = (EEW_PROG_TIME_US * (EEW_CLK_HZ / 1000000));
    localparam int EEW_CNT_W         = 8;
    typedef enum logic [1:0] {
        EEW_IDLE,
        EEW_BYTE,
        EEW_ROWPROG
    } eew_state_e;
endpackage : eew_pkg

// *** verilog/eew_row_latch.sv ***
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// One volatile row latch: data byte plus loaded flag.
module eew_row_latch (
    input  wire logic       mclk,
    input  wire logic       rst,
    input  wire logic       clear,
    input  wire logic       load,
    input  wire logic [7:0] loadData,
    output logic      [7:0] data,
    output logic            loaded
);
    import eew_pkg::*;
    logic [7:0] data_d;
    logic       loaded_d;
    always_comb begin
        data_d   = data;
        loaded_d = loaded;
        if (clear) begin
            loaded_d = 1'b0;
            data_d   = 8'h00;
        end else if (load) begin
            loaded_d = 1'b1;
            data_d   = loadData;
        end
    end
    always_ff @(posedge mclk) begin
        if (rst) begin
            data   <= 8'h00;
            loaded <= 1'b0;
        end else begin
            data   <= data_d;
            loaded <= loaded_d;
        end
    end
endmodule // eew_row_latch
`default_nettype wire
